/* ulb_scheduler.sv */
// What this block does
// RULE1: each port access moves two bytes, low byte even; pointer steps by two
// RULE2: pointer reaching transfer count sets all-done flag and updates buffer status
// RULE3: swap exposed iso half every frame unless both halves already full; with both full the code always exposes half one, moving off half zero
// RULE4: read code for reads, read code plus 80h for writes
// RULE5: largest-packet field and low-speed threshold gate packet starts near frame end
// RULE6: driver programs the iso list length during initialisation
// RULE7: a mixed frame raises iso interrupt first, then async interrupt
// RULE8: iso interrupt flag is set together with start of frame
// RULE9: async interrupt flag follows the iso interrupt; processor clears it
// RULE10: descriptor active bit clears only on full transfer or fatal error
// RULE11: with list serviced and time left, retry a still-active descriptor
// RULE12: finishing an iso half write sets that half's full flag
// RULE13: processing an iso half sets that half's done flag
// RULE14: driver must not write into a half whose full flag is set
// RULE15: at frame start, other half full and processed half done set together
// RULE16: a word read from a done half clears its full and done
// RULE17: flags left set are cleared at the next frame start
// RULE18: async transfer still running at frame start postpones async traffic
// RULE19: iso write still running at frame start suppresses async interrupt
// RULE20: driver keeps control transfer phases in separate async lists
// RULE21: driver schedules at most 1023 bytes per endpoint per frame
// RULE22: processor services interrupts every frame between frames
// RULE23: hardware configuration bit 12 selects internal pull-downs
// RULE24: pull-down select clears on every hardware or software reset
// RULE25: async write sets all-done and async full; irq and done need operational
// RULE26: interrupt flags clear on a written one, a written zero keeps them
`timescale 1ns/1ns
`default_nettype none
`include "ulb_map.svh"
module ulb_scheduler #(
	parameter int FRAME_CYCLES = `ULB_FRAME_US * `ULB_CLK_MHZ,
	parameter int BUF_WORDS = `ULB_BUF_BYTES / `ULB_PORT_STEP,
	parameter int DESC_SLOTS = 8,
	parameter int IW = $clog2(DESC_SLOTS)
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic swReset,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdIn,
	input wire logic dataWrite,
	input wire logic dataRead,
	input wire logic [15:0] dataIn,
	input wire logic isoProcessed,
	input wire logic asyncProcessed,
	input wire logic asyncServiced,
	input wire logic descLoad,
	input wire logic [IW-1:0] descIndex,
	input wire logic descComplete,
	input wire logic descFatal,
	input wire logic [IW-1:0] doneIndex,
	output logic [15:0] dataOut,
	output logic pulldownSelect,
	output logic fsStartOk,
	output logic lsStartOk,
	output logic asyncEnable,
	output logic sofPulse,
	output logic isoEngineHalf,
	output logic retryStart,
	output logic [IW-1:0] retryIndex
);
	// ==========================================================
	// state
	localparam int AW = $clog2(BUF_WORDS);
	ulb_pkg::ulb_port_mode_t mode;
	logic [6:0] cmdReg;
	logic phase;
	logic [15:0] ptr;
	logic [15:0] controlReg;
	logic [31:0] frameInterval;
	logic [31:0] lsThreshold;
	logic [15:0] hwConfig;
	logic [15:0] xferCount;
	logic [15:0] isoLen;
	logic [15:0] asyncLen;
	logic [2:0] intFlags;
	logic asyncFull;
	logic asyncDone;
	logic postpone;
	logic [31:0] frameCnt;
	logic [DESC_SLOTS-1:0] active;
	logic [15:0] mem [BUF_WORDS];
	logic clear;
	ulb_pp_if pp ();

	ulb_pingpong u_pingpong (
		.clk(clk),
		.clear(clear),
		.pp(pp)
	);

	// ==========================================================
	// decoding
	function automatic logic [15:0] regRead(input logic [6:0] cmd,
		input logic hi, input logic [31:0] fi, input logic [31:0] ls,
		input logic [15:0] flags, input logic [15:0] stat);
		logic [15:0] v;
		v = `ULB_RST_WORD;
		unique case (cmd)
			`ULB_CMD_CONTROL: v = controlReg;
			`ULB_CMD_FRAME_INTERVAL: v = hi ? fi[31:16] : fi[15:0];
			`ULB_CMD_LS_THRESHOLD: v = hi ? ls[31:16] : ls[15:0];
			`ULB_CMD_HW_CONFIG: v = hwConfig;
			`ULB_CMD_XFER_COUNT: v = xferCount;
			`ULB_CMD_UP_INT: v = flags;
			`ULB_CMD_ISO_LEN: v = isoLen;
			`ULB_CMD_ASYNC_LEN: v = asyncLen;
			`ULB_CMD_BUF_STATUS: v = stat;
			default: v = `ULB_RST_WORD;
		endcase
		return v;
	endfunction

	function automatic logic [IW-1:0] firstActive(
		input logic [DESC_SLOTS-1:0] act);
		logic [IW-1:0] idx;
		idx = '0;
		for (int i = DESC_SLOTS - 1; i >= 0; i--) begin
			if (act[i])
				idx = IW'(i);
		end
		return idx;
	endfunction

	wire cmdIsWrite = cmdIn[`ULB_CMD_WRITE_BIT]; // [RULE4]
	wire [6:0] cmdCode = cmdIn[6:0];
	wire isIsoPort = (cmdCode == `ULB_CMD_ISO_PORT);
	wire isAsyncPort = (cmdCode == `ULB_CMD_ASYNC_PORT);
	wire isoMode = (mode == ulb_pkg::PORT_ISO_RD) ||
		(mode == ulb_pkg::PORT_ISO_WR);
	wire asyncMode = (mode == ulb_pkg::PORT_ASYNC_RD) ||
		(mode == ulb_pkg::PORT_ASYNC_WR);
	wire bufRd = dataRead && ((mode == ulb_pkg::PORT_ISO_RD) ||
		(mode == ulb_pkg::PORT_ASYNC_RD));
	// writes into a full exposed half are dropped [RULE14]
	wire isoWrRefused = pp.full[pp.cpuHalf];
	wire bufWr = dataWrite && ((mode == ulb_pkg::PORT_ASYNC_WR) ||
		((mode == ulb_pkg::PORT_ISO_WR) && !isoWrRefused));
	wire bufStep = bufRd || bufWr;
	wire [15:0] ptrNext = ptr + 16'(`ULB_PORT_STEP); // [RULE1]
	wire end_of_transfer = bufStep && (ptrNext == xferCount); // [RULE2]
	wire isoHalfSel = (mode == ulb_pkg::PORT_ISO_RD) ? pp.readHalf :
		pp.cpuHalf;
	wire [15:0] isoBase = isoHalfSel ? isoLen : `ULB_RST_WORD;
	wire [15:0] asyncBase = 16'(isoLen << 1);
	wire [15:0] byteAddr = (isoMode ? isoBase : asyncBase) + ptr;
	wire [AW-1:0] wordIdx = byteAddr[AW:1]; // low byte at even address [RULE1]
	wire operational = controlReg[`ULB_CTL_STATE_HI:`ULB_CTL_STATE_LO] ==
		`ULB_CTL_OPERATIONAL;
	wire sof = (frameCnt == 32'(FRAME_CYCLES - 1));
	wire [31:0] remaining = 32'(FRAME_CYCLES - 1) - frameCnt;
	wire [31:0] fsLimit = 32'(frameInterval[`ULB_FS_LARGEST_HI:
		`ULB_FS_LARGEST_LO]);
	wire [31:0] lsLimit = 32'(lsThreshold[`ULB_LS_LIMIT_HI:0]);
	wire [15:0] statusWord = {10'h000, asyncDone, pp.done[1], pp.done[0],
		asyncFull, pp.full[1], pp.full[0]};
	wire regWr = dataWrite && (mode == ulb_pkg::PORT_REG_WR);
	wire [15:0] readValue = (isoMode || asyncMode) ? mem[wordIdx] :
		regRead(cmdReg, phase, frameInterval, lsThreshold,
		{13'h0000, intFlags}, statusWord);
	wire asyncIrqEvent = asyncProcessed && operational && asyncFull &&
		!postpone && intFlags[`ULB_INT_ISO]; // [RULE7] [RULE9] [RULE25]
	wire [2:0] intSet = {end_of_transfer, asyncIrqEvent, sof};
	wire [2:0] intClr = (regWr && cmdReg == `ULB_CMD_UP_INT) ?
		dataIn[2:0] : 3'h0;

	assign clear = !resetn || swReset; // [RULE24]
	assign pp.sof = sof;
	assign pp.writeDone = end_of_transfer && (mode == ulb_pkg::PORT_ISO_WR);
	assign pp.processDone = isoProcessed;
	assign pp.readWord = bufRd && isoMode;

	// ==========================================================
	// command and data port
	always_ff @(posedge clk) begin
		if (clear) begin
			mode <= ulb_pkg::PORT_IDLE;
			cmdReg <= 7'h00;
			phase <= 1'b0;
			ptr <= `ULB_RST_WORD;
		end else if (cmdWrite) begin
			cmdReg <= cmdCode;
			phase <= 1'b0;
			ptr <= `ULB_RST_WORD;
			if (isIsoPort)
				mode <= cmdIsWrite ? ulb_pkg::PORT_ISO_WR :
					ulb_pkg::PORT_ISO_RD;
			else if (isAsyncPort)
				mode <= cmdIsWrite ? ulb_pkg::PORT_ASYNC_WR :
					ulb_pkg::PORT_ASYNC_RD;
			else
				mode <= cmdIsWrite ? ulb_pkg::PORT_REG_WR :
					ulb_pkg::PORT_REG_RD;
		end else begin
			if (dataRead || dataWrite)
				phase <= ~phase;
			if (bufStep)
				ptr <= ptrNext; // [RULE1]
			if (end_of_transfer)
				mode <= ulb_pkg::PORT_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (bufWr)
			mem[wordIdx] <= dataIn;
	end

	always_ff @(posedge clk) begin
		if (clear)
			dataOut <= `ULB_RST_WORD;
		else
			dataOut <= readValue;
	end

	// ==========================================================
	// registers written by the processor
	always_ff @(posedge clk) begin
		if (clear) begin
			controlReg <= `ULB_RST_WORD;
			frameInterval <= `ULB_RST_DWORD;
			lsThreshold <= `ULB_RST_DWORD;
			hwConfig <= `ULB_RST_WORD; // [RULE24]
			xferCount <= `ULB_RST_WORD;
			isoLen <= `ULB_RST_WORD; // [RULE6]
			asyncLen <= `ULB_RST_WORD;
		end else if (regWr) begin
			unique case (cmdReg)
				`ULB_CMD_CONTROL: controlReg <= dataIn;
				`ULB_CMD_FRAME_INTERVAL: begin
					if (phase)
						frameInterval[31:16] <= dataIn;
					else
						frameInterval[15:0] <= dataIn;
				end
				`ULB_CMD_LS_THRESHOLD: begin
					if (phase)
						lsThreshold[31:16] <= dataIn;
					else
						lsThreshold[15:0] <= dataIn;
				end
				`ULB_CMD_HW_CONFIG: hwConfig <= dataIn; // [RULE23]
				`ULB_CMD_XFER_COUNT: xferCount <= dataIn;
				`ULB_CMD_ISO_LEN: isoLen <= dataIn; // [RULE6]
				`ULB_CMD_ASYNC_LEN: asyncLen <= dataIn;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// interrupt flags and async buffer status
	always_ff @(posedge clk) begin
		if (clear) begin
			intFlags <= 3'h0;
			asyncFull <= 1'b0;
			asyncDone <= 1'b0;
		end else begin
			// set wins over a written one [RULE26] [RULE8]
			intFlags <= (intFlags & ~intClr) | intSet;
			if (end_of_transfer && mode == ulb_pkg::PORT_ASYNC_WR)
				asyncFull <= 1'b1; // [RULE25]
			else if (bufRd && asyncMode && asyncDone)
				asyncFull <= 1'b0;
			if (asyncIrqEvent)
				asyncDone <= 1'b1; // [RULE25]
			else if (bufRd && asyncMode)
				asyncDone <= 1'b0;
		end
	end

	// ==========================================================
	// frame timing and scheduling
	always_ff @(posedge clk) begin
		if (clear) begin
			frameCnt <= `ULB_RST_DWORD;
			sofPulse <= 1'b0;
			postpone <= 1'b0;
			fsStartOk <= 1'b0;
			lsStartOk <= 1'b0;
			asyncEnable <= 1'b0;
			isoEngineHalf <= 1'b1;
		end else begin
			frameCnt <= sof ? `ULB_RST_DWORD : frameCnt + 32'h1;
			sofPulse <= sof;
			if (sof)
				postpone <= asyncMode || (mode == ulb_pkg::PORT_ISO_WR);
			fsStartOk <= remaining > fsLimit; // [RULE5]
			lsStartOk <= remaining > lsLimit; // [RULE5]
			// late async transfer or iso write blocks async work [RULE18] [RULE19]
			asyncEnable <= operational && asyncFull && !asyncDone &&
				!postpone && !(sof && (asyncMode ||
				mode == ulb_pkg::PORT_ISO_WR));
			isoEngineHalf <= ~pp.cpuHalf;
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			active <= '0;
			retryStart <= 1'b0;
			retryIndex <= '0;
		end else begin
			for (int i = 0; i < DESC_SLOTS; i++) begin
				if (descLoad && descIndex == IW'(i))
					active[i] <= 1'b1;
				else if ((descComplete || descFatal) && doneIndex == IW'(i))
					active[i] <= 1'b0; // [RULE10]
			end
			// frame not over and room left for a packet [RULE11]
			retryStart <= asyncServiced && (|active) && fsStartOk &&
				asyncEnable && !sof;
			retryIndex <= firstActive(active); // [RULE11]
		end
	end

	wire pulldownSelectNext = hwConfig[`ULB_HW_PULLDOWN];
	always_ff @(posedge clk) begin
		if (clear)
			pulldownSelect <= 1'b0;
		else
			pulldownSelect <= pulldownSelectNext; // [RULE23]
	end
endmodule
`default_nettype wire

/* ulb_map.svh */
`ifndef ULB_MAP_SVH
`define ULB_MAP_SVH
// command codes (read form), write form sets the top bit
`define ULB_CMD_WRITE_BIT 7
`define ULB_CMD_CONTROL 7'h01
`define ULB_CMD_FRAME_INTERVAL 7'h0d
`define ULB_CMD_LS_THRESHOLD 7'h11
`define ULB_CMD_HW_CONFIG 7'h20
`define ULB_CMD_XFER_COUNT 7'h22
`define ULB_CMD_UP_INT 7'h24
`define ULB_CMD_ISO_LEN 7'h2a
`define ULB_CMD_ASYNC_LEN 7'h2b
`define ULB_CMD_BUF_STATUS 7'h2c
`define ULB_CMD_ISO_PORT 7'h40
`define ULB_CMD_ASYNC_PORT 7'h41
// processor interrupt flag bits
`define ULB_INT_ISO 0
`define ULB_INT_ASYNC 1
`define ULB_INT_ALL_DONE 2
// buffer status bits
`define ULB_BS_PING_FULL 0
`define ULB_BS_PONG_FULL 1
`define ULB_BS_ASYNC_FULL 2
`define ULB_BS_PING_DONE 3
`define ULB_BS_PONG_DONE 4
`define ULB_BS_ASYNC_DONE 5
// hardware configuration, frame interval and low-speed threshold fields
`define ULB_HW_PULLDOWN 12
`define ULB_FS_LARGEST_HI 30
`define ULB_FS_LARGEST_LO 16
`define ULB_LS_LIMIT_HI 11
// control register operational-state field and its code
`define ULB_CTL_STATE_HI 7
`define ULB_CTL_STATE_LO 6
`define ULB_CTL_OPERATIONAL 2'h2
// reset values
`define ULB_RST_WORD 16'h0000
`define ULB_RST_DWORD 32'h00000000
// timing and sizes
`define ULB_FRAME_US 1000
`define ULB_CLK_MHZ 10
`define ULB_BUF_BYTES 4096
`define ULB_PORT_STEP 2
`endif

/* ulb_pkg.sv */
package ulb_pkg;
	typedef enum logic [2:0] {
		PORT_IDLE,
		PORT_REG_RD,
		PORT_REG_WR,
		PORT_ISO_RD,
		PORT_ISO_WR,
		PORT_ASYNC_RD,
		PORT_ASYNC_WR
	} ulb_port_mode_t;
endpackage

/* ulb_pp_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ulb_pp_if;
	logic sof;
	logic writeDone;
	logic processDone;
	logic readWord;
	logic [1:0] full;
	logic [1:0] done;
	logic cpuHalf;
	logic readHalf;
	modport tracker (input sof, writeDone, processDone, readWord,
		output full, done, cpuHalf, readHalf);
	modport user (output sof, writeDone, processDone, readWord,
		input full, done, cpuHalf, readHalf);
endinterface
`default_nettype wire

/* ulb_pingpong.sv */
`timescale 1ns/1ns
`default_nettype none
module ulb_pingpong (
	input wire logic clk,
	input wire logic clear,
	ulb_pp_if.tracker pp
);
	// ==========================================================
	// ping-pong flag tracking
	logic [1:0] full;
	logic [1:0] done;
	logic cpuHalf;
	logic [1:0] next_full;
	logic [1:0] next_done;
	logic next_cpuHalf;
	logic engHalf;

	assign engHalf = ~cpuHalf;
	assign pp.full = full;
	assign pp.done = done;
	assign pp.cpuHalf = cpuHalf;
	// a finished half is read back first, whichever half is exposed
	assign pp.readHalf = done[0] ? 1'b0 : (done[1] ? 1'b1 : cpuHalf);

	always_comb begin
		next_full = full;
		next_done = done;
		next_cpuHalf = cpuHalf;
		if (pp.sof) begin
			// exposed half still left done by the driver is dropped [RULE17]
			next_full[cpuHalf] = full[cpuHalf] & ~done[cpuHalf];
			next_done = 2'b00;
			// half under processing finishes at the boundary [RULE13] [RULE15]
			if (full[engHalf])
				next_done[engHalf] = 1'b1;
			// while both halves are full the processor gets half one, even from half zero [RULE3]
			if (full == 2'b11)
				next_cpuHalf = 1'b1;
			else
				next_cpuHalf = engHalf;
		end else if (pp.processDone && full[engHalf]) begin
			next_done[engHalf] = 1'b1; // [RULE13]
		end
		if (pp.writeDone)
			next_full[cpuHalf] = 1'b1; // [RULE12]
		// a word read from a done half clears both of its flags [RULE16]
		if (pp.readWord && done[pp.readHalf]) begin
			next_full[pp.readHalf] = 1'b0;
			next_done[pp.readHalf] = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (clear) begin
			full <= 2'b00;
			done <= 2'b00;
			cpuHalf <= 1'b0;
		end else begin
			full <= next_full;
			done <= next_done;
			cpuHalf <= next_cpuHalf;
		end
	end
endmodule
`default_nettype wire

/* ulb_scheduler_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module ulb_scheduler_checker #(
	parameter int FRAME_CYCLES = 50,
	parameter int IW = 3
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic swReset,
	input wire logic cmdWrite,
	input wire logic [7:0] cmdIn,
	input wire logic dataWrite,
	input wire logic [15:0] dataIn,
	input wire logic descLoad,
	input wire logic [IW-1:0] descIndex,
	input wire logic descComplete,
	input wire logic descFatal,
	input wire logic [IW-1:0] doneIndex,
	input wire logic [15:0] dataOut,
	input wire logic pulldownSelect,
	input wire logic fsStartOk,
	input wire logic sofPulse,
	input wire logic isoEngineHalf,
	input wire logic retryStart,
	input wire logic [IW-1:0] retryIndex
);
	// ==========
	// shadow of the programmed state
	localparam int N = 2 ** IW;
	logic [7:0] lastCmd;
	logic hiWord;
	logic [14:0] fsLim;
	logic [15:0] isoLen;
	logic [N-1:0] act, actOld, next_act, actAny;
	int gap;
	wire fiWr = dataWrite && lastCmd == 8'h8d;
	wire pdWr = dataWrite && lastCmd == 8'ha0;
	assign next_act = (act & ~(N'(descComplete || descFatal) << doneIndex))
		| (N'(descLoad) << descIndex);
	assign actAny = act | actOld;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge clk) begin
		if (!resetn || swReset) begin
			lastCmd <= 8'h00;
			hiWord <= 1'b0;
			fsLim <= 15'h0000;
			isoLen <= 16'h0000;
			act <= '0;
			actOld <= '0;
			gap <= 0;
		end else begin
			if (cmdWrite) lastCmd <= cmdIn;
			hiWord <= cmdWrite ? 1'b0 : hiWord ^ fiWr;
			if (fiWr && hiWord) fsLim <= dataIn[14:0];
			if (dataWrite && lastCmd == 8'haa) isoLen <= dataIn;
			act <= next_act;
			actOld <= act;
			gap <= sofPulse ? 0 : gap + 1;
		end
	end
	sequence s_pdWr;
		pdWr && !swReset;
	endsequence
	sequence s_quiet;
		(!sofPulse) [*8];
	endsequence
	a_pulldown_write: assert property (
		s_pdWr |=> ##1 pulldownSelect == $past(dataIn[12], 2))
		else $error("pull-down select missed a write");
	a_pulldown_hold: assert property (
		!pdWr && !$past(pdWr) && !swReset |=> $stable(pulldownSelect))
		else $error("pull-down select changed unasked");
	a_sw_clear: assert property (swReset |=> !pulldownSelect)
		else $error("pull-down select survived reset");
	a_sof_single: assert property (sofPulse |=> s_quiet)
		else $error("frame start repeated too soon");
	a_frame_period: assert property (gap <= FRAME_CYCLES + 1)
		else $error("frame start overdue");
	a_fs_limit: assert property (
		(fsLim >= FRAME_CYCLES) [*2] |-> !fsStartOk)
		else $error("full-speed start allowed past limit");
	a_iso_len_read: assert property (
		cmdWrite && cmdIn == 8'h2a |=> ##1 dataOut == isoLen)
		else $error("iso list length read back wrong");
	a_retry_active: assert property (
		retryStart |-> actAny[retryIndex])
		else $error("retry of an inactive descriptor");
	a_half_swap: assert property (
		$changed(isoEngineHalf) |-> sofPulse || $past(sofPulse)
		|| $past(swReset))
		else $error("iso half moved outside frame start");
endmodule
bind ulb_scheduler ulb_scheduler_checker #(.FRAME_CYCLES(FRAME_CYCLES),
	.IW(IW)) u_ulb_scheduler_checker (.clk(clk), .resetn(resetn),
	.swReset(swReset), .cmdWrite(cmdWrite), .cmdIn(cmdIn),
	.dataWrite(dataWrite), .dataIn(dataIn), .descLoad(descLoad),
	.descIndex(descIndex), .descComplete(descComplete),
	.descFatal(descFatal), .doneIndex(doneIndex), .dataOut(dataOut),
	.pulldownSelect(pulldownSelect), .fsStartOk(fsStartOk),
	.sofPulse(sofPulse), .isoEngineHalf(isoEngineHalf),
	.retryStart(retryStart), .retryIndex(retryIndex));
`default_nettype wire

/* ulb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ulb_host_model (
	input wire logic clk,
	input wire logic [15:0] dataOut,
	output logic cmdWrite,
	output logic [7:0] cmdIn,
	output logic dataWrite,
	output logic dataRead,
	output logic [15:0] dataIn
);
	// ==========
	// processor side of the command/data port
	initial begin
		cmdWrite = 1'b0;
		cmdIn = 8'h00;
		dataWrite = 1'b0;
		dataRead = 1'b0;
		dataIn = 16'h0000;
	end
	// released lines show the inverse so stale values never match
	task cmd(input logic [7:0] c);
		@(posedge clk);
		cmdWrite <= 1'b1;
		cmdIn <= c;
		@(posedge clk);
		cmdWrite <= 1'b0;
		cmdIn <= ~c;
	endtask
	task wr(input logic [15:0] d);
		@(posedge clk);
		dataWrite <= 1'b1;
		dataIn <= d;
		@(posedge clk);
		dataWrite <= 1'b0;
		dataIn <= ~d;
	endtask
	task pop();
		@(posedge clk);
		dataRead <= 1'b1;
		@(posedge clk);
		dataRead <= 1'b0;
	endtask
	task reg_wr(input logic [7:0] c, input logic [15:0] d);
		cmd(c);
		wr(d);
	endtask
	task reg_rd(input logic [7:0] c, output logic [15:0] v);
		cmd(c);
		@(posedge clk);
		#1;
		v = dataOut;
	endtask
endmodule
`default_nettype wire

/* ulb_scheduler_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module ulb_scheduler_bench;
	logic clk, resetn, swReset;
	logic isoProcessed, asyncProcessed, asyncServiced;
	logic descLoad, descComplete, descFatal;
	logic [2:0] descIndex, doneIndex, retryIndex;
	logic cmdWrite, dataWrite, dataRead;
	logic [7:0] cmdIn;
	logic [15:0] dataIn, dataOut, v;
	logic pulldownSelect, fsStartOk, lsStartOk, asyncEnable;
	logic sofPulse, isoEngineHalf, retryStart;
	int error_cnt = 0;
	int n_checks = 0;
	ulb_scheduler #(.FRAME_CYCLES(50), .BUF_WORDS(64)) u_ulb_scheduler (
		.clk(clk), .resetn(resetn), .swReset(swReset),
		.cmdWrite(cmdWrite), .cmdIn(cmdIn), .dataWrite(dataWrite),
		.dataRead(dataRead), .dataIn(dataIn), .isoProcessed(isoProcessed),
		.asyncProcessed(asyncProcessed), .asyncServiced(asyncServiced),
		.descLoad(descLoad), .descIndex(descIndex),
		.descComplete(descComplete), .descFatal(descFatal),
		.doneIndex(doneIndex), .dataOut(dataOut),
		.pulldownSelect(pulldownSelect), .fsStartOk(fsStartOk),
		.lsStartOk(lsStartOk), .asyncEnable(asyncEnable),
		.sofPulse(sofPulse), .isoEngineHalf(isoEngineHalf),
		.retryStart(retryStart), .retryIndex(retryIndex));
	ulb_host_model u_ulb_host_model (.clk(clk), .dataOut(dataOut),
		.cmdWrite(cmdWrite), .cmdIn(cmdIn), .dataWrite(dataWrite),
		.dataRead(dataRead), .dataIn(dataIn));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// ==========
	// helpers
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task pulse(input int b);
		@(posedge clk);
		isoProcessed <= (b == 0);
		asyncProcessed <= (b == 1);
		descLoad <= (b == 3);
		descComplete <= (b == 4);
		descFatal <= (b == 5);
		@(posedge clk);
		{isoProcessed, asyncProcessed, descLoad} <= 3'h0;
		{descComplete, descFatal} <= 2'h0;
	endtask
	task sw_rst();
		@(posedge clk);
		swReset <= 1'b1;
		@(posedge clk);
		swReset <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_sig(input string n, ref logic s);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge clk);
			#1;
			if (s === 1'b1) break;
		end
		chk(n, 16'h1, {15'h0, s});
	endtask
	task async_fill();
		u_ulb_host_model.reg_wr(8'ha2, 16'h0004);
		u_ulb_host_model.cmd(8'hc1);
		u_ulb_host_model.wr(16'h0201);
		u_ulb_host_model.wr(16'h0403);
	endtask
	// ==========
	// scenarios
	task t_pulldown();
		chk("pulldown rst", 16'h0, {15'h0, pulldownSelect});
		u_ulb_host_model.reg_wr(8'ha0, 16'h1000);
		repeat (2) @(posedge clk);
		#1;
		chk("pulldown set", 16'h1, {15'h0, pulldownSelect});
		u_ulb_host_model.reg_rd(8'h20, v);
		chk("hw cfg read", 16'h1000, v & 16'h1000);
		sw_rst();
		chk("pulldown sw", 16'h0, {15'h0, pulldownSelect});
	endtask
	task t_async_idle();
		sw_rst();
		async_fill();
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("irq idle", 16'h0004, v & 16'h0006);
		u_ulb_host_model.reg_rd(8'h2c, v);
		chk("status idle", 16'h0004, v & 16'h0024);
		u_ulb_host_model.reg_wr(8'ha4, 16'h0000);
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("zero keeps", 16'h0004, v & 16'h0004);
		u_ulb_host_model.reg_wr(8'ha4, 16'h0004);
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("one clears", 16'h0000, v & 16'h0004);
	endtask
	task t_mixed();
		sw_rst();
		u_ulb_host_model.reg_wr(8'h81, 16'h0080);
		wait_sig("sof", sofPulse);
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("iso first", 16'h0001, v & 16'h0003);
		async_fill();
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("async wait", 16'h0005, v & 16'h0007);
		pulse(1);
		u_ulb_host_model.reg_rd(8'h24, v);
		chk("async next", 16'h0007, v & 16'h0007);
		u_ulb_host_model.reg_rd(8'h2c, v);
		chk("async done", 16'h0024, v & 16'h0024);
	endtask
	task lim(input logic [7:0] c, input logic [15:0] lo, hi, e);
		u_ulb_host_model.cmd(c);
		u_ulb_host_model.wr(lo);
		u_ulb_host_model.wr(hi);
		wait_sig("sof", sofPulse);
		repeat (10) @(posedge clk);
		#1;
		chk("start ok", e, {14'h0, fsStartOk, lsStartOk});
	endtask
	task t_limits();
		sw_rst();
		lim(8'h8d, 16'h0031, 16'h7fff, 16'h1);
		lim(8'h91, 16'h0fff, 16'h0000, 16'h0);
		lim(8'h8d, 16'h0031, 16'h0000, 16'h2);
		lim(8'h91, 16'h0000, 16'h0000, 16'h3);
	endtask
	task t_pingpong();
		sw_rst();
		u_ulb_host_model.reg_wr(8'haa, 16'h0008);
		u_ulb_host_model.reg_rd(8'h2a, v);
		chk("iso len", 16'h0008, v);
		u_ulb_host_model.reg_wr(8'ha2, 16'h0004);
		u_ulb_host_model.cmd(8'hc0);
		u_ulb_host_model.wr(16'h1111);
		u_ulb_host_model.wr(16'h2222);
		u_ulb_host_model.reg_rd(8'h2c, v);
		chk("ping full", 16'h0001, v & 16'h0001);
		wait_sig("sof", sofPulse);
		@(posedge clk);
		#1;
		chk("engine half", 16'h0, {15'h0, isoEngineHalf});
		pulse(0);
		wait_sig("sof", sofPulse);
		u_ulb_host_model.reg_rd(8'h2c, v);
		chk("ping done", 16'h0009, v & 16'h0009);
		u_ulb_host_model.cmd(8'h40);
		u_ulb_host_model.pop();
		u_ulb_host_model.reg_rd(8'h2c, v);
		chk("ping freed", 16'h0000, v & 16'h0009);
	endtask
	task t_retry(input logic [2:0] i, input int endBit);
		@(posedge clk);
		descIndex <= i;
		doneIndex <= i;
		asyncServiced <= 1'b1;
		pulse(3);
		wait_sig("retry", retryStart);
		chk("retry idx", {13'h0, i}, {13'h0, retryIndex});
		pulse(endBit);
		repeat (3) @(posedge clk);
		#1;
		chk("retry stop", 16'h0, {15'h0, retryStart});
		@(posedge clk);
		asyncServiced <= 1'b0;
	endtask
	initial begin
		resetn = 1'b0;
		swReset = 1'b0;
		{isoProcessed, asyncProcessed, asyncServiced} = 3'h0;
		{descLoad, descComplete, descFatal} = 3'h0;
		descIndex = 3'h0;
		doneIndex = 3'h0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_pulldown();
		t_async_idle();
		t_mixed();
		t_limits();
		t_pingpong();
		sw_rst();
		u_ulb_host_model.reg_wr(8'h81, 16'h0080);
		async_fill();
		t_retry(3'h5, 4);
		t_retry(3'h2, 5);
		wrap_up();
	end
	initial begin
		#3000000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
